// *** sfs_consts.svh ***
// Constants of the secondary fault supervisor
// Functional notes
// R1 - Open rectifier pin stops requests, restarts
// R2 - Grounded rectifier pin disables drive, check
// R3 - Valley gating on in DCM, off CCM
// R4 - Valley-only requests for 20 us
// R5 - Blank on-cycle detection about 1 us
// R6 - Constant power above knee, CV-CP-CC
// R7 - Power limit uses full-scale, not setting
// R8 - Cable drop 0-600 mV, linear load
// R9 - Voltage-only: overload timer 8-64 ms
// R10 - Overload expiry response, default ignore/8ms
// R11 - Undervoltage stays active in voltage-only
// R12 - Sink detect, reference from advertisement
// R13 - Marked cable detect, advertisement reference
// R14 - VCONN soft-start closes, faults open
// R15 - OV/UV response, UV time selectable
// R16 - Overvoltage qualified after 80 us
// R17 - Sense-short fault with frequency limit
// R18 - Surge fault at three times threshold
// R19 - Real output short always restarts
// R20 - Firmware ignores surge during start-up
// R21 - Bus switch open restores defaults, 5V
// R22 - Bus closed: fast sampling, bleeder off
// R23 - Fault detection raises controller interrupt
// R24 - Fault responses default to restart, except overload (ignore)
// R25 - Response settings act on next evaluation
`ifndef SFS_CONSTS_SVH
`define SFS_CONSTS_SVH
`define SFS_ADDR_CTRL 8'h00
`define SFS_ADDR_RESP 8'h04
`define SFS_ADDR_LVL 8'h08
`define SFS_ADDR_STAT 8'h0c
`define SFS_RESP_IGNORE 2'h0
`define SFS_RESP_RETRY 2'h1
`define SFS_RESP_SHUT 2'h2
`define SFS_CLK_MHZ 50
`define SFS_CLK_KHZ 50000
`define SFS_QR_WIN_US 20
`define SFS_BLANK_US 1
`define SFS_OV_DLY_US 80
`define SFS_SR_TEST_US 2
`define SFS_TMR_BASE_MS 8
`define SFS_SS_F0_KHZ 30
`define SFS_SS_F1_KHZ 40
`define SFS_SS_F2_KHZ 50
`define SFS_SS_F3_KHZ 60
`define SFS_CDC_STEP_MV 10'h032
`define SFS_CDC_MAX_CODE 4'hc
`define SFS_IFS 8'h80
`define SFS_IFS_SHIFT 7
`define SFS_VSET_5V 12'h1f4
`define SFS_KNEE_RST 12'hfff
`define SFS_CC_RST 8'h80
`define SFS_CTRL_RST 32'h0000_0000
`define SFS_RESP_RST 32'h0000_0115
`define SFS_NFLT 7
`endif

// *** sfs_pkg.sv ***
// Types of the secondary fault supervisor
`default_nettype none
package sfs_pkg;
    typedef struct packed {
        logic [21:0] rsvd; // Reads zero
        logic ss_en; // Sense-short check on
        logic [1:0] advert; // Advertised current
        logic [3:0] cdc_code; // Cable drop steps
        logic cvo_en; // Voltage-only mode
        logic cp_en; // Constant power on
        logic bus_sw; // VBUS switch closed
    } sfs_ctrl_t;
    typedef struct packed {
        logic [16:0] rsvd; // Reads zero
        logic [1:0] ss_fsel; // Frequency limit
        logic [1:0] plt_sel; // Overload timer
        logic [1:0] uv_sel; // UV detection time
        logic surge_retry; // Surge restarts
        logic [1:0] ol_resp; // Overload response
        logic [1:0] ss_resp; // Sense-short response
        logic [1:0] uv_resp; // UV response
        logic [1:0] ov_resp; // OV response
    } sfs_resp_t;
    typedef struct packed {
        logic [11:0] knee; // Knee voltage, 10 mV
        logic [7:0] cc_set; // Current set point
        logic [11:0] vset; // Setpoint, 10 mV
    } sfs_lvl_t;
    typedef struct packed {
        logic sr_above_ref; // Pin load below 100 pF
        logic sr_grounded; // Pin tied low
        logic dcm; // Discontinuous conduction
        logic fwd_neg; // Forward pin low
        logic valley; // Valley window
        logic ov_cmp; // Output over threshold
        logic uv_cmp; // Output under threshold
        logic sense_low; // Sense below half scale
        logic sense_surge; // Sense above 3x
        logic out_short; // Output shorted
        logic cc_sink; // Sink comparator
        logic cc_emark; // Marker comparator
        logic cc_flip; // Sink on CC2
        logic vconn_oc; // VCONN overcurrent
        logic vconn_short; // VCONN short
    } sfs_pins_t;
    typedef enum logic [1:0] {SR_TEST, SR_RUN, SR_OFF, SR_OPEN} sfs_sr_t;
    typedef enum logic [1:0] {MODE_CV, MODE_CP, MODE_CC} sfs_mode_t;
    typedef struct packed {
        logic [15:0] rsvd; // Reads zero
        logic latched; // Shut down
        logic vc_on; // VCONN closed
        logic emark; // Marked cable
        logic sink; // Sink attached
        logic [1:0] mode; // Regulation region
        logic [1:0] sr_st; // Rectifier pin state
        logic [0:0] pad; // Reads zero
        logic [6:0] flt; // Sticky faults
    } sfs_stat_t;
endpackage : sfs_pkg
`default_nettype wire

// *** sfs_supervisor.sv ***
// Secondary fault supervisor with APB register slave
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "sfs_consts.svh"
module sfs_supervisor #(
    parameter int TMR_BASE_CYC = `SFS_TMR_BASE_MS * `SFS_CLK_MHZ * 1000
) (
    input wire logic pclk, // 50 MHz clock
    input wire logic presetn, // Async reset, low
    input wire logic ce, // Clock enable
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire sfs_pkg::sfs_pins_t pins, // Async comparators
    input wire logic req_raise, // Loop wants a cycle
    input wire logic [7:0] iload, // Load current code
    input wire logic [11:0] vout, // Output voltage code
    output logic cycle_req, // Request to primary
    output logic sync_rectifier_drive, // Drive enable
    output logic vconn_cc1_en, // VCONN onto CC1
    output logic vconn_cc2_en, // VCONN onto CC2
    output logic [7:0] vconn_gate, // Soft-start level
    output logic retry_after_fault, // Restart pulse
    output logic permanent_shutdown, // Latched off
    output logic fault_irq, // Fault interrupt
    output logic sink_attached, // Sink present
    output logic emarker_seen, // Marked cable
    output logic [1:0] cc_ref_sel, // Comparator reference
    output logic bus_switch_en, // VBUS switch drive
    output logic fast_sample, // Fast ADC rate
    output logic bleeder_off, // Bleeder inhibit
    output logic [11:0] vout_setpoint, // Setpoint
    output logic [7:0] cc_limit, // Current limit
    output logic [1:0] reg_mode, // Regulation region
    output logic [9:0] cable_drop_comp // Offset, mV
);
    // Cycle counts derived from times
    localparam int QR_CYC = `SFS_QR_WIN_US * `SFS_CLK_MHZ;
    localparam int BLANK_CYC = `SFS_BLANK_US * `SFS_CLK_MHZ;
    localparam int OV_CYC = `SFS_OV_DLY_US * `SFS_CLK_MHZ;
    localparam int TEST_CYC = `SFS_SR_TEST_US * `SFS_CLK_MHZ;
    // Fault bit positions
    localparam int F_OV = 0;
    localparam int F_UV = 1;
    localparam int F_OL = 2;
    localparam int F_SS = 3;
    localparam int F_SG = 4;
    localparam int F_VC = 5;
    localparam int F_SR = 6;

    // Whole module state
    typedef struct packed {
        sfs_pkg::sfs_ctrl_t ctrl; // Control register
        sfs_pkg::sfs_resp_t rsp; // Response register
        sfs_pkg::sfs_lvl_t lvl; // Level register
        logic [`SFS_NFLT-1:0] flt; // Sticky faults
        sfs_pkg::sfs_pins_t sync1; // First stage
        sfs_pkg::sfs_pins_t sync2; // Second stage
        logic fwd_d; // Forward history
        logic dcm_d; // DCM history
        logic bus_d; // Switch history
        sfs_pkg::sfs_sr_t sr_st; // Rectifier pin state
        logic srd; // Rectifier drive out
        logic [7:0] sr_cnt; // Test time
        logic [10:0] qr_cnt; // Valley window
        logic [5:0] blank_cnt; // Blanking
        logic [11:0] per_cnt; // Cycle period
        logic [12:0] ov_cnt; // OV qualification
        logic [22:0] uv_cnt; // UV qualification
        logic [22:0] ol_cnt; // Overload timer
        logic [7:0] vc_ramp; // VCONN gate ramp
        logic vc1; // VCONN on CC1
        logic vc2; // VCONN on CC2
        logic sink; // Sink seen
        logic emark; // Marker seen
        logic cyc_req; // Request out
        logic restart; // Restart pulse
        logic latched; // Shut down
        logic irq; // Interrupt out
        sfs_pkg::sfs_mode_t mode; // Region
        logic [9:0] cdc; // Drop offset
        logic pready; // Bus ready
        logic pslverr; // Bus error
        logic [31:0] prdata; // Bus data
    } sfs_state_t;

    sfs_state_t s_reg; // Registered state
    sfs_state_t s_next; // Next state
    sfs_pkg::sfs_pins_t p; // Synchronised pins
    logic on_edge; // Primary on-cycle seen
    logic [`SFS_NFLT-1:0] ev; // Fault events
    logic [`SFS_NFLT-1:0] clr; // Software clears

    // Detection time for 8/16/32/64 ms options
    function automatic logic [22:0] tmr_lim(input logic [1:0] sel);
        tmr_lim = 23'(TMR_BASE_CYC) << sel;
    endfunction : tmr_lim

    // Period under which frequency is too high
    function automatic logic [11:0] per_lim(input logic [1:0] sel);
        case (sel)
            2'h0: per_lim = 12'(`SFS_CLK_KHZ / `SFS_SS_F0_KHZ);
            2'h1: per_lim = 12'(`SFS_CLK_KHZ / `SFS_SS_F1_KHZ);
            2'h2: per_lim = 12'(`SFS_CLK_KHZ / `SFS_SS_F2_KHZ);
            default: per_lim = 12'(`SFS_CLK_KHZ / `SFS_SS_F3_KHZ);
        endcase
    endfunction : per_lim

    // Offset grows linearly to full at full-scale current
    function automatic logic [9:0] cdc_mv(input logic [3:0] code,
                                          input logic [7:0] cur);
        logic [3:0] c;
        logic [7:0] i;
        logic [17:0] prod;
        c = (code > `SFS_CDC_MAX_CODE) ? `SFS_CDC_MAX_CODE : code;
        i = (cur > `SFS_IFS) ? `SFS_IFS : cur;
        prod = 18'(c) * 18'(`SFS_CDC_STEP_MV) * 18'(i);
        cdc_mv = 10'(prod >> `SFS_IFS_SHIFT);
    endfunction : cdc_mv

    // Reserved codes act as restart, the safe choice
    function automatic logic is_shut(input logic [1:0] r);
        is_shut = (r == `SFS_RESP_SHUT);
    endfunction : is_shut
    function automatic logic is_retry(input logic [1:0] r);
        is_retry = (r != `SFS_RESP_IGNORE) && (r != `SFS_RESP_SHUT);
    endfunction : is_retry

    // Next-state logic for the whole block
    always_comb begin
        logic [19:0] pwr;
        logic [19:0] knee_pwr;
        logic hit;
        logic [31:0] rd;
        pwr = 20'(iload) * 20'(vout);
        knee_pwr = 20'(s_reg.lvl.knee) * 20'(`SFS_IFS);
        hit = 1'b0;
        rd = 32'h0000_0000;
        s_next = s_reg;
        ev = '0;
        clr = '0;
        // Two-stage synchroniser
        s_next.sync1 = pins;
        s_next.sync2 = s_reg.sync1;
        p = s_reg.sync2;
        s_next.restart = 1'b0;
        s_next.fwd_d = p.fwd_neg;
        s_next.dcm_d = p.dcm;
        s_next.bus_d = s_reg.ctrl.bus_sw;
        // On-cycle detect, ringing blanked afterwards
        on_edge = p.fwd_neg && !s_reg.fwd_d && (s_reg.blank_cnt == '0);
        if (on_edge) begin
            s_next.blank_cnt = 6'(BLANK_CYC); // [R5]
        end else if (s_reg.blank_cnt != '0) begin
            s_next.blank_cnt = s_reg.blank_cnt - 6'h01;
        end
        // Period between on-cycles, saturating
        if (on_edge) begin
            s_next.per_cnt = '0;
        end else if (s_reg.per_cnt != '1) begin
            s_next.per_cnt = s_reg.per_cnt + 12'h001;
        end
        // Rectifier pin test at start-up
        case (s_reg.sr_st)
            sfs_pkg::SR_TEST: begin
                s_next.sr_cnt = s_reg.sr_cnt + 8'h01;
                if (s_reg.sr_cnt == 8'(TEST_CYC)) begin
                    if (p.sr_grounded) begin
                        s_next.sr_st = sfs_pkg::SR_OFF; // [R2]
                    end else if (p.sr_above_ref) begin
                        s_next.sr_st = sfs_pkg::SR_OPEN; // [R1]
                        ev[F_SR] = 1'b1;
                        s_next.restart = 1'b1; // [R1]
                    end else begin
                        s_next.sr_st = sfs_pkg::SR_RUN;
                    end
                end
            end
            sfs_pkg::SR_RUN: s_next.sr_st = sfs_pkg::SR_RUN;
            sfs_pkg::SR_OFF: s_next.sr_st = sfs_pkg::SR_OFF;
            sfs_pkg::SR_OPEN: s_next.sr_st = sfs_pkg::SR_OPEN;
            default: s_next.sr_st = sfs_pkg::SR_TEST;
        endcase
        s_next.srd = (s_next.sr_st == sfs_pkg::SR_RUN); // [R2]
        // Valley window opens on entry to DCM
        if (!p.dcm) begin
            s_next.qr_cnt = '0; // [R3]
        end else if (!s_reg.dcm_d) begin
            s_next.qr_cnt = 11'(QR_CYC); // [R3] [R4]
        end else if (s_reg.qr_cnt != '0) begin
            s_next.qr_cnt = s_reg.qr_cnt - 11'h001; // [R4]
        end
        // Requests only while valley or window over
        s_next.cyc_req = req_raise && !s_reg.latched
            && (s_reg.sr_st == sfs_pkg::SR_RUN || s_reg.sr_st == sfs_pkg::SR_OFF)
            && (s_reg.qr_cnt == '0 || p.valley); // [R1] [R4]
        // Region: current limit first, then power knee
        if (!s_reg.ctrl.cvo_en && iload >= s_reg.lvl.cc_set) begin
            s_next.mode = sfs_pkg::MODE_CC; // [R6]
        end else if (s_reg.ctrl.cp_en && vout > s_reg.lvl.knee
                     && pwr >= knee_pwr) begin
            s_next.mode = sfs_pkg::MODE_CP; // [R6] [R7]
        end else begin
            s_next.mode = sfs_pkg::MODE_CV;
        end
        s_next.cdc = cdc_mv(s_reg.ctrl.cdc_code, iload); // [R8]
        // Overvoltage qualification
        if (!p.ov_cmp) begin
            s_next.ov_cnt = '0;
        end else if (s_reg.ov_cnt != 13'(OV_CYC)) begin
            s_next.ov_cnt = s_reg.ov_cnt + 13'h0001;
            ev[F_OV] = (s_reg.ov_cnt == 13'(OV_CYC - 1)); // [R16]
        end
        // Undervoltage, active in every mode
        if (!p.uv_cmp) begin
            s_next.uv_cnt = '0;
        end else if (s_reg.uv_cnt != tmr_lim(s_reg.rsp.uv_sel)) begin
            s_next.uv_cnt = s_reg.uv_cnt + 23'h000001;
            ev[F_UV] = (s_reg.uv_cnt == tmr_lim(s_reg.rsp.uv_sel) - 23'h1); // [R11] [R15]
        end
        // Peak load timer in voltage-only mode
        if (!(s_reg.ctrl.cvo_en && iload > s_reg.lvl.cc_set)) begin
            s_next.ol_cnt = '0;
        end else if (s_reg.ol_cnt != tmr_lim(s_reg.rsp.plt_sel)) begin
            s_next.ol_cnt = s_reg.ol_cnt + 23'h000001; // [R9]
            ev[F_OL] = (s_reg.ol_cnt == tmr_lim(s_reg.rsp.plt_sel) - 23'h1); // [R10]
        end
        // Sense short: low sense at high frequency
        ev[F_SS] = s_reg.ctrl.ss_en && on_edge && p.sense_low
            && (s_reg.per_cnt < per_lim(s_reg.rsp.ss_fsel)); // [R17]
        ev[F_SG] = (p.sense_surge && s_reg.rsp.surge_retry) || p.out_short; // [R18]
        ev[F_VC] = (s_reg.vc1 || s_reg.vc2) && (p.vconn_oc || p.vconn_short);
        // Programmed responses, read at evaluation time
        if ((ev[F_OV] && is_retry(s_reg.rsp.ov_resp)) // [R15] [R25]
            || (ev[F_UV] && is_retry(s_reg.rsp.uv_resp))
            || (ev[F_OL] && is_retry(s_reg.rsp.ol_resp)) // [R10]
            || (ev[F_SS] && is_retry(s_reg.rsp.ss_resp)) // [R17]
            || ev[F_SG]) begin // [R18] [R19]
            s_next.restart = 1'b1;
        end
        if ((ev[F_OV] && is_shut(s_reg.rsp.ov_resp))
            || (ev[F_UV] && is_shut(s_reg.rsp.uv_resp))
            || (ev[F_OL] && is_shut(s_reg.rsp.ol_resp))
            || (ev[F_SS] && is_shut(s_reg.rsp.ss_resp))) begin
            s_next.latched = 1'b1; // [R15]
        end
        // Type-C comparators
        s_next.sink = p.cc_sink; // [R12]
        s_next.emark = p.cc_emark; // [R13]
        // VCONN with soft-started gate
        if (ev[F_VC] || !p.cc_emark || s_reg.flt[F_VC]) begin
            s_next.vc1 = 1'b0; // [R14]
            s_next.vc2 = 1'b0;
            s_next.vc_ramp = '0;
        end else begin
            s_next.vc1 = !p.cc_flip; // [R14]
            s_next.vc2 = p.cc_flip;
            if (s_reg.vc_ramp != '1) begin
                s_next.vc_ramp = s_reg.vc_ramp + 8'h01;
            end
        end
        // APB read decode
        case (paddr)
            `SFS_ADDR_CTRL: begin
                hit = 1'b1;
                rd = s_reg.ctrl;
            end
            `SFS_ADDR_RESP: begin
                hit = 1'b1;
                rd = s_reg.rsp;
            end
            `SFS_ADDR_LVL: begin
                hit = 1'b1;
                rd = s_reg.lvl;
            end
            `SFS_ADDR_STAT: begin
                hit = 1'b1;
                rd = sfs_pkg::sfs_stat_t'({16'h0000, s_reg.latched,
                    s_reg.vc1 | s_reg.vc2, s_reg.emark, s_reg.sink,
                    s_reg.mode, s_reg.sr_st, 1'b0, s_reg.flt});
            end
            default: hit = 1'b0;
        endcase
        // Three-cycle access: ready one cycle after enable
        s_next.pready = 1'b0;
        s_next.pslverr = 1'b0;
        if (psel && penable && !s_reg.pready) begin
            s_next.pready = 1'b1;
            s_next.pslverr = !hit;
            s_next.prdata = hit ? rd : 32'h0000_0000;
        end
        if (psel && penable && s_reg.pready && pwrite && hit) begin
            case (paddr)
                `SFS_ADDR_CTRL: s_next.ctrl = sfs_pkg::sfs_ctrl_t'(pwdata & 32'h0000_03ff);
                `SFS_ADDR_RESP: s_next.rsp = sfs_pkg::sfs_resp_t'(pwdata & 32'h0000_7fff); // [R25]
                `SFS_ADDR_LVL: s_next.lvl = pwdata;
                default: clr = pwdata[`SFS_NFLT-1:0];
            endcase
        end
        // Opening the switch restores defaults
        if (s_reg.bus_d && !s_reg.ctrl.bus_sw) begin
            s_next.rsp = sfs_pkg::sfs_resp_t'(`SFS_RESP_RST); // [R21] [R24]
            s_next.lvl.vset = `SFS_VSET_5V; // [R21]
            s_next.lvl.knee = `SFS_KNEE_RST;
            s_next.lvl.cc_set = `SFS_CC_RST;
        end
        // Set wins over a simultaneous clear
        s_next.flt = (s_reg.flt & ~clr) | ev;
        s_next.irq = |s_next.flt; // [R23]
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
            s_reg.rsp <= sfs_pkg::sfs_resp_t'(`SFS_RESP_RST); // [R10] [R24]
            s_reg.lvl <= sfs_pkg::sfs_lvl_t'({`SFS_KNEE_RST, `SFS_CC_RST, `SFS_VSET_5V});
            s_reg.sr_st <= sfs_pkg::SR_TEST;
            s_reg.mode <= sfs_pkg::MODE_CV;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from state
    assign prdata = s_reg.prdata;
    assign pready = s_reg.pready;
    assign pslverr = s_reg.pslverr;
    assign cycle_req = s_reg.cyc_req;
    assign sync_rectifier_drive = s_reg.srd; // [R2]
    assign vconn_cc1_en = s_reg.vc1;
    assign vconn_cc2_en = s_reg.vc2;
    assign vconn_gate = s_reg.vc_ramp;
    assign retry_after_fault = s_reg.restart;
    assign permanent_shutdown = s_reg.latched;
    assign fault_irq = s_reg.irq;
    assign sink_attached = s_reg.sink;
    assign emarker_seen = s_reg.emark;
    assign cc_ref_sel = s_reg.ctrl.advert; // [R12] [R13]
    assign bus_switch_en = s_reg.ctrl.bus_sw; // Firmware owns it after faults
    assign fast_sample = s_reg.ctrl.bus_sw; // [R22]
    assign bleeder_off = s_reg.ctrl.bus_sw; // [R22]
    assign vout_setpoint = s_reg.lvl.vset;
    assign cc_limit = s_reg.lvl.cc_set;
    assign reg_mode = s_reg.mode;
    assign cable_drop_comp = s_reg.cdc;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !ce);

    sequence seq_on_cycle;
        on_edge;
    endsequence
    sequence seq_bus_open;
        s_reg.bus_d && !s_reg.ctrl.bus_sw;
    endsequence

    sr_open_stop_a: assert property (s_reg.sr_st == sfs_pkg::SR_OPEN |=> !cycle_req) // [R1]
        else $error("request while rectifier pin open");
    sr_gnd_off_a: assert property (s_reg.sr_st == sfs_pkg::SR_OFF |-> !sync_rectifier_drive) // [R2]
        else $error("rectifier drive on with pin grounded");
    qr_ccm_a: assert property (!p.dcm |=> s_reg.qr_cnt == '0) // [R3]
        else $error("valley window open in CCM");
    qr_gate_a: assert property (s_reg.qr_cnt != '0 && !p.valley |=> !cycle_req) // [R4]
        else $error("request outside valley window");
    blank_load_a: assert property (seq_on_cycle |=> s_reg.blank_cnt == 6'(BLANK_CYC) ##1 !on_edge) // [R5]
        else $error("on-cycle blanking missing");
    cdc_zero_a: assert property (iload == 8'h00 |=> cable_drop_comp == 10'h000) // [R8]
        else $error("drop offset at no load");
    ov_qual_a: assert property ($rose(s_reg.flt[F_OV]) |-> s_reg.ov_cnt == 13'(OV_CYC)) // [R16]
        else $error("overvoltage flagged before delay");
    short_retry_a: assert property (p.out_short |=> retry_after_fault) // [R19]
        else $error("output short without restart");
    bus_open_a: assert property (seq_bus_open |=> vout_setpoint == `SFS_VSET_5V) // [R21]
        else $error("setpoint not restored on switch open");
    vconn_trip_a: assert property (ev[F_VC] |=> !vconn_cc1_en && !vconn_cc2_en) // [R14]
        else $error("VCONN stayed on after fault");
    irq_raise_a: assert property ($rose(|s_reg.flt) |-> fault_irq) // [R23]
        else $error("no interrupt on fault");
endmodule : sfs_supervisor
`default_nettype wire

// *** sfs_primary_model.sv ***
// Primary switching controller model that answers cycle requests
`timescale 1ns/100ps
`default_nettype none
module sfs_primary_model #(
    parameter int DLY = 3 // Cycles from request to on-cycle
) (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic cycle_req, // Request from the secondary
    output logic fwd_neg // Forward pin swings low
);
    int cnt; // Delay to the on-cycle
    // One on-cycle per request, only after a delay, like the real switch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            fwd_neg <= 1'b0;
        end else if (cycle_req && cnt == 0) begin
            cnt <= DLY;
            fwd_neg <= 1'b0;
        end else begin
            cnt <= (cnt > 0) ? cnt - 1 : 0;
            fwd_neg <= (cnt == 1); // Single pulse, the sync flops still catch it
        end
    end
endmodule : sfs_primary_model
`default_nettype wire

// *** secondary_fault_supervisor_tb_top.sv ***
// Self-checking bench of the secondary fault supervisor
`timescale 1ns/100ps
`default_nettype none
module secondary_fault_supervisor_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fwd, req, er; // Bus and loop
    logic cyc, srd, fs, bo, irq, sd, em, vc2; // Observed levels
    logic [7:0] paddr, iload; // Address, load code
    logic [11:0] vout, vsp; // Voltage in and setpoint out
    logic [9:0] cdc; // Cable drop offset
    logic [1:0] md; // Regulation region
    logic [31:0] pwdata, prdata, rd; // Bus data
    sfs_pkg::sfs_pins_t pdrv, pins; // Comparator levels
    int errors, check_count, cycles; // Verdict counters
    // Short timer base keeps the millisecond timers cheap
    sfs_supervisor #(.TMR_BASE_CYC(20)) i_sfs_supervisor (.pclk(pclk), .presetn(presetn),
        .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
        .req_raise(req), .iload(iload), .vout(vout), .cycle_req(cyc),
        .sync_rectifier_drive(srd), .vconn_cc1_en(), .vconn_cc2_en(vc2), .vconn_gate(),
        .retry_after_fault(), .permanent_shutdown(sd), .fault_irq(irq), .sink_attached(),
        .emarker_seen(em), .cc_ref_sel(), .bus_switch_en(), .fast_sample(fs),
        .bleeder_off(bo), .vout_setpoint(vsp), .cc_limit(), .reg_mode(md),
        .cable_drop_comp(cdc));
    sfs_primary_model i_sfs_primary_model (.pclk(pclk), .presetn(presetn),
        .cycle_req(cyc), .fwd_neg(fwd));
    // Forward pin comes from the primary model, the rest from the bench
    always_comb begin
        pins = pdrv;
        pins.fwd_neg = fwd;
    end
    initial forever #10 pclk = ~pclk;
    // Hang guard, well above the longest scenario
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            conclude();
        end
    end
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask : wt
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s exp %h got %h", s, e, g);
        end
    endtask : chk
    // One APB transfer; holds everything until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        wt(1);
    endtask : apb
    // Reset, then let the rectifier pin test finish
    task automatic rst();
        presetn <= 1'b0;
        wt(8);
        presetn <= 1'b1;
        wt(110);
    endtask : rst
    task automatic conclude();
        if (errors == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    task automatic t_defaults();
        int n;
        n = 0;
        apb(1'b0, 8'h04, 32'h0);
        chk("resp", 32'h0000_0115, rd);
        chk("vset", 32'h1f4, 32'(vsp));
        chk("srd", 1, 32'(srd));
        req <= 1'b1;
        while (cyc !== 1'b1 && n < 50) begin
            wt(1);
            n++;
        end
        chk("req", 1, 32'(cyc));
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped", 32'h1, {rd[30:0], er});
    endtask : t_defaults
    task automatic t_cdc();
        apb(1'b1, 8'h00, 32'h0000_0060);
        iload <= 8'h80;
        wt(5);
        chk("cdc full", 32'h258, 32'(cdc));
        iload <= 8'h40;
        wt(5);
        chk("cdc half", 32'h12c, 32'(cdc));
    endtask : t_cdc
    task automatic t_bus();
        apb(1'b1, 8'h04, 32'h0000_0015);
        apb(1'b1, 8'h00, 32'h1);
        wt(3);
        chk("fast/bleed", 32'h3, {fs, bo});
        apb(1'b1, 8'h08, 32'h0000_03e8);
        apb(1'b1, 8'h04, 32'h0000_0100);
        apb(1'b1, 8'h00, 32'h0);
        wt(3);
        chk("vset back", 32'h1f4, 32'(vsp));
        apb(1'b0, 8'h04, 32'h0);
        chk("resp back", 32'h115, rd);
    endtask : t_bus
    task automatic t_ov();
        apb(1'b1, 8'h04, 32'h0000_0154);
        pdrv.ov_cmp <= 1'b1;
        wt(3990);
        apb(1'b0, 8'h0c, 32'h0);
        chk("ov early", 32'h0, rd & 32'h8001);
        wt(20);
        apb(1'b0, 8'h0c, 32'h0);
        chk("ov flag", 32'h1, rd & 32'h8001);
        chk("irq", 1, 32'(irq));
        apb(1'b1, 8'h04, 32'h0000_0158);
        pdrv.uv_cmp <= 1'b1;
        wt(30);
        chk("uv latch", 1, 32'(sd));
        {pdrv.ov_cmp, pdrv.uv_cmp} <= 2'b00;
    endtask : t_ov
    // Power knee region, then VCONN onto CC2 and its trip
    task automatic t_mode();
        apb(1'b1, 8'h08, 32'h100f_f1f4);
        apb(1'b1, 8'h00, 32'h0000_0002);
        iload <= 8'h50;
        pdrv.cc_emark <= 1'b1;
        pdrv.cc_flip <= 1'b1;
        wt(4);
        chk("cp", 32'h1, 32'(md));
        chk("vconn", 32'h3, {em, vc2});
        iload <= 8'h30;
        pdrv.vconn_oc <= 1'b1;
        wt(4);
        chk("cv", 32'h0, 32'(md));
        chk("vconn off", 32'h0, 32'(vc2));
    endtask : t_mode
    // Rectifier pin variants need a fresh start-up each
    task automatic t_sr(input logic open, input logic [31:0] st);
        pdrv.sr_above_ref <= open;
        pdrv.sr_grounded <= ~open;
        rst();
        apb(1'b0, 8'h0c, 32'h0);
        chk("sr state", st, 32'(rd[9:8]));
        chk("sr drive", 0, 32'(srd));
        if (open) chk("no req", 0, 32'(cyc));
        else chk("req kept", 1, 32'(cyc));
    endtask : t_sr
    initial begin
        pclk = 0;
        {presetn, psel, penable, pwrite, req, paddr, pwdata} = '0;
        {pdrv, iload, errors, check_count, cycles} = '0;
        vout = 12'h1f4;
        rst();
        t_defaults();
        t_cdc();
        t_bus();
        t_ov();
        t_mode();
        t_sr(1'b1, 32'h3);
        t_sr(1'b0, 32'h2);
        conclude();
    end
endmodule : secondary_fault_supervisor_tb_top
`default_nettype wire
